// ---- src/fwepr_defs.svh ----
// Constant definitions for the wrap, ECC status and protection registers
`ifndef FWEPR_DEFS_SVH
`define FWEPR_DEFS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FWEPR_OP_GEN_RD 8'h65
`define FWEPR_OP_GEN_WR 8'h71
`define FWEPR_OP_BURST_SET 8'hc0
`define FWEPR_OP_ECC_RD_A 8'h18
`define FWEPR_OP_ECC_RD_B 8'h19
`define FWEPR_OP_PROT_RD 8'h2b
`define FWEPR_OP_PROT_PROG 8'h2f

// ----------------------------------------------------------------
// Generic register addresses
// ----------------------------------------------------------------
`define FWEPR_ADR_STATUS 24'h000000
`define FWEPR_ADR_WRAP_NV 24'h000005
`define FWEPR_ADR_WRAP_V 24'h800005
`define FWEPR_ADR_PROT 24'h000030

// ----------------------------------------------------------------
// Wrap configuration fields
// ----------------------------------------------------------------
`define FWEPR_WRAP_DIS_BIT 4
`define FWEPR_DRIVE_MSB 7
`define FWEPR_DRIVE_LSB 5
`define FWEPR_WLEN_MSB 1
`define FWEPR_WLEN_LSB 0
`define FWEPR_WRAP_MASK 8'hf3
`define FWEPR_WLEN_8 8'h08
`define FWEPR_WLEN_16 8'h10
`define FWEPR_WLEN_32 8'h20
`define FWEPR_WLEN_64 8'h40

// ----------------------------------------------------------------
// Status, ECC and protection fields
// ----------------------------------------------------------------
`define FWEPR_PERR_BIT 6
`define FWEPR_ECC_CODE_BIT 2
`define FWEPR_ECC_DATA_BIT 1
`define FWEPR_ECC_DIS_BIT 0
`define FWEPR_ECC_UNIT_SHIFT 4
`define FWEPR_PWD_LOCK_BIT 2
`define FWEPR_PST_LOCK_BIT 1
`define FWEPR_PROT_OPEN 2'h3
`define FWEPR_PROT_BOTH 2'h0

`endif

// ---- src/fwepr_device.sv ----
// Flash-side register bank: burst wrap, ECC unit status, protection OTP
// Functional notes
// - Bit 4 zero enables wrap, one sequential
// - Wrap codes select 8, 16, 32, 64 bytes
// - Any reset reloads volatile wrap from twin
// - Wrap register via generic access and C0h
// - Drive select in bits 7:5, applied immediately
// - ECC read 18h/19h plus unit address
// - Each ECC unit covers sixteen data bytes
// - Status bit 2 flags code bit error
// - Status bit 1 flags corrected data error
// - Status bit 0 flags correction disabled
// - Status bits 7:3 arbitrary, host ignores them
// - ECC status read-only, hardware set, resets zero
// - Protection register is 16 OTP bits
// - Bit 2 zero selects password mode forever
// - Bit 1 zero selects persistent mode forever
// - Programming both lock bits zero is rejected
// - Programming allowed only while bits 2:1 open
// - Committed mode locks the whole register
// - Other OTP config also needs open state
// - Host programs OTP config before commit
// - Host commits mode during system configuration
// - Protection read 2Bh, program 2Fh, generic too
`timescale 1ns/1ps
`include "fwepr_defs.svh"
module fwepr_device #(
    parameter int ECC_UNITS = 16,
    parameter int UNIT_AW = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic soft_reset,
    // Command link
    fwepr_if.dev link,
    // Non-volatile images
    input wire logic [7:0] boot_wrap_cfg,
    input wire logic [15:0] prot_otp_cells,
    // ECC events from the read path
    input wire logic ecc_evt_valid,
    input wire logic [UNIT_AW-1:0] ecc_evt_unit,
    input wire logic ecc_evt_code_err,
    input wire logic ecc_evt_data_err,
    input wire logic ecc_evt_disabled,
    // Configuration outputs
    output logic [2:0] drive_sel,
    output logic wrap_enable,
    output logic [7:0] wrap_len_bytes,
    output logic prog_err_flag,
    output logic password_mode,
    output logic persistent_mode,
    // OTP burn requests
    output logic prot_burn_valid,
    output logic [15:0] prot_burn_data,
    output logic cfg_burn_valid,
    output logic [7:0] cfg_burn_data
);
    import fwepr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] wrap_cfg_q, wrap_cfg_d;
    logic load_q;
    logic perr_q, perr_d;
    logic [2:0] ecc_stat_q [ECC_UNITS];
    logic [4:0] noise_q;
    logic rsp_valid_q, rsp_err_q;
    logic [15:0] rsp_data_q, rd_data;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic cmd, is_gen_rd, is_gen_wr, is_ecc, wrap_wr, prot_open;
    logic prot_req, prot_bad, cfg_req, cfg_bad, perr_clr;
    logic [UNIT_AW-1:0] unit_sel;
    logic [7:0] ecc_byte;

    assign cmd = link.cmd_valid;
    assign is_gen_rd = cmd && link.cmd_op == `FWEPR_OP_GEN_RD;
    assign is_gen_wr = cmd && link.cmd_op == `FWEPR_OP_GEN_WR;
    assign is_ecc = cmd && (link.cmd_op == `FWEPR_OP_ECC_RD_A ||
        link.cmd_op == `FWEPR_OP_ECC_RD_B);
    // Burst set and generic write both reach the volatile copy
    assign wrap_wr = cmd && (link.cmd_op == `FWEPR_OP_BURST_SET ||
        (is_gen_wr && link.cmd_addr == `FWEPR_ADR_WRAP_V));
    // Programming is only possible before a mode is committed
    assign prot_open = prot_otp_cells[`FWEPR_PWD_LOCK_BIT:
        `FWEPR_PST_LOCK_BIT] == `FWEPR_PROT_OPEN;
    assign prot_req = (cmd && link.cmd_op == `FWEPR_OP_PROT_PROG) ||
        (is_gen_wr && link.cmd_addr == `FWEPR_ADR_PROT);
    assign prot_bad = prot_req && (!prot_open ||
        link.cmd_wdata[`FWEPR_PWD_LOCK_BIT:`FWEPR_PST_LOCK_BIT] ==
        `FWEPR_PROT_BOTH);
    assign cfg_req = is_gen_wr && link.cmd_addr == `FWEPR_ADR_WRAP_NV;
    assign cfg_bad = cfg_req && !prot_open;
    assign perr_clr = is_gen_wr && link.cmd_addr == `FWEPR_ADR_STATUS &&
        !link.cmd_wdata[`FWEPR_PERR_BIT];
    // Sixteen-byte units: the byte address drops its low four bits
    assign unit_sel = link.cmd_addr[`FWEPR_ECC_UNIT_SHIFT +: UNIT_AW];

    // Status byte of the selected unit; upper bits are free noise
    assign ecc_byte = {noise_q, ecc_stat_q[unit_sel]};

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 16'h0000;
        if (is_ecc) begin
            rd_data = {8'h00, ecc_byte};
        end else if (cmd && link.cmd_op == `FWEPR_OP_PROT_RD) begin
            rd_data = prot_otp_cells;
        end else if (is_gen_rd) begin
            unique case (link.cmd_addr)
                `FWEPR_ADR_STATUS: rd_data = {9'h000, perr_q, 6'h00};
                `FWEPR_ADR_WRAP_NV: rd_data = {8'h00, boot_wrap_cfg};
                `FWEPR_ADR_WRAP_V: rd_data = {8'h00, wrap_cfg_q};
                `FWEPR_ADR_PROT: rd_data = prot_otp_cells;
                default: rd_data = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Volatile wrap configuration
    // ------------------------------------------------------------
    // Reset load wins over a command in the same cycle
    always_comb begin
        wrap_cfg_d = wrap_cfg_q;
        if (load_q || soft_reset) begin
            wrap_cfg_d = boot_wrap_cfg & `FWEPR_WRAP_MASK;
        end else if (wrap_wr) begin
            wrap_cfg_d = link.cmd_wdata[7:0] & `FWEPR_WRAP_MASK;
        end
    end

    // The twin is a port, so the copy happens one edge after release
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            load_q <= 1'b1;
            wrap_cfg_q <= 8'h00;
        end else begin
            load_q <= 1'b0;
            wrap_cfg_q <= wrap_cfg_d;
        end
    end

    // Decoded outputs follow the next value so they land with it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            drive_sel <= 3'h0;
            wrap_enable <= 1'b0;
            wrap_len_bytes <= `FWEPR_WLEN_8;
        end else begin
            drive_sel <= wrap_cfg_d[`FWEPR_DRIVE_MSB:`FWEPR_DRIVE_LSB];
            wrap_enable <= !wrap_cfg_d[`FWEPR_WRAP_DIS_BIT];
            unique case (wrap_cfg_d[`FWEPR_WLEN_MSB:`FWEPR_WLEN_LSB])
                2'h0: wrap_len_bytes <= `FWEPR_WLEN_8;
                2'h1: wrap_len_bytes <= `FWEPR_WLEN_16;
                2'h2: wrap_len_bytes <= `FWEPR_WLEN_32;
                2'h3: wrap_len_bytes <= `FWEPR_WLEN_64;
            endcase
        end
    end

    // ------------------------------------------------------------
    // ECC unit status
    // ------------------------------------------------------------
    // Sticky until reset; no command can touch these bits
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < ECC_UNITS; i++) begin
                ecc_stat_q[i] <= 3'h0;
            end
        end else if (ecc_evt_valid) begin
            ecc_stat_q[ecc_evt_unit] <= ecc_stat_q[ecc_evt_unit] |
                {ecc_evt_code_err, ecc_evt_data_err,
                ecc_evt_disabled};
        end
    end

    // Free-running filler so software cannot rely on reserved bits
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            noise_q <= 5'h00;
        end else begin
            noise_q <= noise_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Program error flag
    // ------------------------------------------------------------
    // A new error wins over a clear in the same cycle
    always_comb begin
        perr_d = perr_q;
        if (perr_clr) begin
            perr_d = 1'b0;
        end
        if (prot_bad || cfg_bad) begin
            perr_d = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            perr_q <= 1'b0;
            prog_err_flag <= 1'b0;
        end else begin
            perr_q <= perr_d;
            prog_err_flag <= perr_d;
        end
    end

    // ------------------------------------------------------------
    // OTP burn requests and protection mode
    // ------------------------------------------------------------
    // OTP cells only go from one to zero, hence the AND
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prot_burn_valid <= 1'b0;
            prot_burn_data <= 16'hffff;
            cfg_burn_valid <= 1'b0;
            cfg_burn_data <= 8'hff;
            password_mode <= 1'b0;
            persistent_mode <= 1'b0;
        end else begin
            prot_burn_valid <= prot_req && !prot_bad;
            prot_burn_data <= prot_otp_cells & link.cmd_wdata;
            cfg_burn_valid <= cfg_req && !cfg_bad;
            cfg_burn_data <= boot_wrap_cfg & link.cmd_wdata[7:0];
            password_mode <= !prot_otp_cells[`FWEPR_PWD_LOCK_BIT];
            persistent_mode <= !prot_otp_cells[`FWEPR_PST_LOCK_BIT];
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
            rsp_err_q <= 1'b0;
        end else begin
            rsp_valid_q <= cmd;
            rsp_data_q <= rd_data;
            rsp_err_q <= prot_bad || cfg_bad;
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_data = rsp_data_q;
    assign link.rsp_err = rsp_err_q;

endmodule

// ---- src/fwepr_host.sv ----
// Host-side controller issuing register commands over the link
`timescale 1ns/1ps
`include "fwepr_defs.svh"
module fwepr_host (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Command link
    fwepr_if.host link,
    // User request
    input wire logic req_valid,
    input wire fwepr_pkg::fwepr_kind_t req_kind,
    input wire logic [23:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    // User answer
    output logic done,
    output logic [15:0] rdata,
    output logic err
);
    import fwepr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fwepr_state_t state_q;
    fwepr_kind_t kind_q;
    logic cmd_valid_q;
    logic [7:0] cmd_op_q, op_d;
    logic [23:0] cmd_addr_q;
    logic [15:0] cmd_wdata_q;

    // Opcode for each kind of request
    always_comb begin
        unique case (req_kind)
            FWEPR_K_GEN_RD: op_d = `FWEPR_OP_GEN_RD;
            FWEPR_K_GEN_WR: op_d = `FWEPR_OP_GEN_WR;
            FWEPR_K_BURST_SET: op_d = `FWEPR_OP_BURST_SET;
            FWEPR_K_ECC_RD: op_d = `FWEPR_OP_ECC_RD_A;
            FWEPR_K_PROT_RD: op_d = `FWEPR_OP_PROT_RD;
            FWEPR_K_PROT_PROG: op_d = `FWEPR_OP_PROT_PROG;
            default: op_d = `FWEPR_OP_GEN_RD;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer: one command outstanding at a time
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= FWEPR_S_IDLE;
            kind_q <= FWEPR_K_GEN_RD;
            req_ready <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_op_q <= 8'h00;
            cmd_addr_q <= 24'h000000;
            cmd_wdata_q <= 16'h0000;
        end else begin
            cmd_valid_q <= 1'b0;
            unique case (state_q)
                FWEPR_S_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        state_q <= FWEPR_S_WAIT;
                        kind_q <= req_kind;
                        req_ready <= 1'b0;
                        cmd_valid_q <= 1'b1;
                        cmd_op_q <= op_d;
                        cmd_addr_q <= req_addr;
                        cmd_wdata_q <= req_wdata;
                    end
                end
                FWEPR_S_WAIT: begin
                    if (link.rsp_valid) begin
                        state_q <= FWEPR_S_IDLE;
                        req_ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answer capture
    // ------------------------------------------------------------
    // Reserved ECC bits vary from read to read, so they are dropped
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            done <= 1'b0;
            rdata <= 16'h0000;
            err <= 1'b0;
        end else begin
            done <= state_q == FWEPR_S_WAIT && link.rsp_valid;
            if (state_q == FWEPR_S_WAIT && link.rsp_valid) begin
                err <= link.rsp_err;
                if (kind_q == FWEPR_K_ECC_RD) begin
                    rdata <= link.rsp_data & 16'h0007;
                end else begin
                    rdata <= link.rsp_data;
                end
            end
        end
    end

    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_op = cmd_op_q;
    assign link.cmd_addr = cmd_addr_q;
    assign link.cmd_wdata = cmd_wdata_q;

endmodule

// ---- src/fwepr_if.sv ----
// Command link between the host controller and the flash register bank
`timescale 1ns/1ps
interface fwepr_if;
    // Command from host
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [23:0] cmd_addr;
    logic [15:0] cmd_wdata;
    // Answer from device
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic rsp_err;

    modport dev (
        input cmd_valid, cmd_op, cmd_addr, cmd_wdata,
        output rsp_valid, rsp_data, rsp_err
    );
    modport host (
        output cmd_valid, cmd_op, cmd_addr, cmd_wdata,
        input rsp_valid, rsp_data, rsp_err
    );
endinterface

// ---- src/fwepr_pkg.sv ----
// Types shared by both ends of the register command link
package fwepr_pkg;

    // Kind of command the host user asks for
    typedef enum logic [2:0] {
        FWEPR_K_GEN_RD = 3'h0,
        FWEPR_K_GEN_WR = 3'h1,
        FWEPR_K_BURST_SET = 3'h2,
        FWEPR_K_ECC_RD = 3'h3,
        FWEPR_K_PROT_RD = 3'h4,
        FWEPR_K_PROT_PROG = 3'h5
    } fwepr_kind_t;

    // Host sequencer states, Gray coded
    typedef enum logic [1:0] {
        FWEPR_S_IDLE = 2'h0,
        FWEPR_S_WAIT = 2'h1
    } fwepr_state_t;

endpackage

// ---- test/flash_wrap_ecc_protect_regs_test.sv ----
// Self-checking bench joining host controller and register bank
`timescale 1ns/1ps
module flash_wrap_ecc_protect_regs_test;
    import fwepr_pkg::*;

    typedef struct {
        fwepr_kind_t kind;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp_data;
        logic exp_err;
    } fwepr_row_t;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_reset = 1'b0;
    logic [7:0] boot_wrap_cfg = 8'hb7;
    logic [15:0] prot_otp_cells = 16'hffff;
    logic ecc_evt_valid = 1'b0;
    logic [3:0] ecc_evt_unit = 4'h0;
    logic [2:0] ecc_evt_bits = 3'h0;
    logic req_valid = 1'b0;
    fwepr_kind_t req_kind = FWEPR_K_GEN_RD;
    logic [23:0] req_addr = 24'h000000;
    logic [15:0] req_wdata = 16'h0000;
    logic [2:0] drive_sel;
    logic [7:0] wrap_len_bytes;
    logic [7:0] cfg_burn_data;
    logic [15:0] prot_burn_data;
    logic [15:0] rdata;
    logic wrap_enable, prog_err_flag, password_mode, persistent_mode;
    logic prot_burn_valid, cfg_burn_valid, req_ready, done, err;
    logic [2:0] c;
    int n_fail = 0;
    int samples_checked = 0;
    fwepr_row_t rows [23];

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    fwepr_if link ();
    fwepr_device u_fwepr_device (.clock(clock), .sys_rst(sys_rst),
        .soft_reset(soft_reset), .link(link),
        .boot_wrap_cfg(boot_wrap_cfg), .prot_otp_cells(prot_otp_cells),
        .ecc_evt_valid(ecc_evt_valid), .ecc_evt_unit(ecc_evt_unit),
        .ecc_evt_code_err(ecc_evt_bits[2]),
        .ecc_evt_data_err(ecc_evt_bits[1]),
        .ecc_evt_disabled(ecc_evt_bits[0]), .drive_sel(drive_sel),
        .wrap_enable(wrap_enable), .wrap_len_bytes(wrap_len_bytes),
        .prog_err_flag(prog_err_flag), .password_mode(password_mode),
        .persistent_mode(persistent_mode),
        .prot_burn_valid(prot_burn_valid), .prot_burn_data(prot_burn_data),
        .cfg_burn_valid(cfg_burn_valid), .cfg_burn_data(cfg_burn_data));
    fwepr_host u_fwepr_host (.clock(clock), .sys_rst(sys_rst),
        .link(link), .req_valid(req_valid), .req_kind(req_kind),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .done(done), .rdata(rdata), .err(err));
    fwepr_assertions u_fwepr_assertions (.clock(clock), .sys_rst(sys_rst),
        .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
        .cmd_addr(link.cmd_addr), .cmd_wdata(link.cmd_wdata),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
        .rsp_err(link.rsp_err));

    // 200 MHz clock
    always #2.5 clock = ~clock;

    // OTP cells and nonvolatile twin change on a burn pulse; the sequence also sets the cells fresh at the second reset
    always @(posedge clock) begin
        if (prot_burn_valid === 1'b1) prot_otp_cells <= prot_burn_data;
        if (cfg_burn_valid === 1'b1) boot_wrap_cfg <= cfg_burn_data;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One user request; holds it until taken, then waits for done
    task automatic do_req(input fwepr_kind_t k, input logic [23:0] a,
        input logic [15:0] w);
        int n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        req_valid = 1'b1;
        req_kind = k;
        req_addr = a;
        req_wdata = w;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 20) n_fail++;
    endtask

    // Sticky ECC event from the read path
    task automatic ecc_evt(input logic [3:0] u, input logic [2:0] b);
        @(posedge clock);
        #1;
        ecc_evt_valid = 1'b1;
        ecc_evt_unit = u;
        ecc_evt_bits = b;
        @(posedge clock);
        #1;
        ecc_evt_valid = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{
            '{FWEPR_K_GEN_RD, 24'h800005, 16'h0000, 16'h00b3, 1'b0},
            '{FWEPR_K_GEN_WR, 24'h800005, 16'h00e6, 16'h0000, 1'b0},
            '{FWEPR_K_GEN_RD, 24'h800005, 16'h0000, 16'h00e2, 1'b0},
            '{FWEPR_K_BURST_SET, 24'h000000, 16'h0011, 16'h0000, 1'b0},
            '{FWEPR_K_GEN_RD, 24'h800005, 16'h0000, 16'h0011, 1'b0},
            '{FWEPR_K_PROT_RD, 24'h000000, 16'h0000, 16'hffff, 1'b0},
            '{FWEPR_K_ECC_RD, 24'h000030, 16'h0000, 16'h0004, 1'b0},
            '{FWEPR_K_ECC_RD, 24'h00003f, 16'h0000, 16'h0004, 1'b0},
            '{FWEPR_K_ECC_RD, 24'h000040, 16'h0000, 16'h0000, 1'b0},
            '{FWEPR_K_ECC_RD, 24'h000050, 16'h0000, 16'h0002, 1'b0},
            '{FWEPR_K_ECC_RD, 24'h000090, 16'h0000, 16'h0001, 1'b0},
            '{FWEPR_K_PROT_PROG, 24'h000000, 16'hfff9, 16'h0000, 1'b1},
            '{FWEPR_K_GEN_RD, 24'h000000, 16'h0000, 16'h0040, 1'b0},
            '{FWEPR_K_PROT_RD, 24'h000000, 16'h0000, 16'hffff, 1'b0},
            '{FWEPR_K_GEN_WR, 24'h000000, 16'h0000, 16'h0000, 1'b0},
            '{FWEPR_K_GEN_RD, 24'h000000, 16'h0000, 16'h0000, 1'b0},
            '{FWEPR_K_GEN_WR, 24'h000005, 16'h00ef, 16'h0000, 1'b0},
            '{FWEPR_K_PROT_PROG, 24'h000000, 16'hfffb, 16'h0000, 1'b0},
            '{FWEPR_K_PROT_PROG, 24'h000000, 16'hfffd, 16'h0000, 1'b1},
            '{FWEPR_K_GEN_WR, 24'h000030, 16'h0000, 16'h0000, 1'b1},
            '{FWEPR_K_GEN_WR, 24'h000005, 16'h0000, 16'h0000, 1'b1},
            '{FWEPR_K_GEN_RD, 24'h000030, 16'h0000, 16'hfffb, 1'b0},
            '{FWEPR_K_GEN_RD, 24'h000000, 16'h0000, 16'h0040, 1'b0}};
        repeat (4) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        @(posedge clock);
        #1;
        chk("drive_sel", {13'h0, drive_sel}, 16'h0005);
        chk("wrap_enable", {15'h0, wrap_enable}, 16'h0000);
        chk("wrap_len", {8'h0, wrap_len_bytes}, 16'h0040);
        ecc_evt(4'h3, 3'h4);
        ecc_evt(4'h5, 3'h2);
        ecc_evt(4'h9, 3'h1);
        foreach (rows[i]) begin
            do_req(rows[i].kind, rows[i].addr, rows[i].wdata);
            chk("rdata", rdata, rows[i].exp_data);
            chk("err", {15'h0, err}, {15'h0, rows[i].exp_err});
        end
        repeat (2) @(posedge clock);
        #1;
        chk("password_mode", {15'h0, password_mode}, 16'h0001);
        chk("persistent_mode", {15'h0, persistent_mode}, 16'h0000);
        chk("prog_err_flag", {15'h0, prog_err_flag}, 16'h0001);
        // Every wrap length code, wrap state and drive value
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            do_req(FWEPR_K_BURST_SET, 24'h0, {8'h00, c, c[0], 2'b00, c[1:0]});
            chk("drive_sel", {13'h0, drive_sel}, {13'h0, c});
            chk("wrap_enable", {15'h0, wrap_enable}, {15'h0, ~c[0]});
            chk("wrap_len", 16'(wrap_len_bytes), 16'h8 << c[1:0]);
        end
        do_req(FWEPR_K_PROT_RD, 24'h0, 16'h0);
        soft_reset = 1'b1;
        @(posedge clock);
        #1;
        soft_reset = 1'b0;
        do_req(FWEPR_K_GEN_RD, 24'h800005, 16'h0);
        chk("rdata", rdata, 16'h00a3);
        // Second reset with a fresh OTP part
        sys_rst = 1'b1;
        prot_otp_cells = 16'hffff;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        do_req(FWEPR_K_ECC_RD, 24'h000030, 16'h0);
        chk("rdata", rdata, 16'h0000);
        do_req(FWEPR_K_PROT_PROG, 24'h0, 16'hfffd);
        do_req(FWEPR_K_PROT_RD, 24'h0, 16'h0);
        chk("rdata", rdata, 16'hfffd);
        chk("persistent_mode", {15'h0, persistent_mode}, 16'h0001);
        chk("password_mode", {15'h0, password_mode}, 16'h0000);
        test_done();
    end

    // Cut a hang short; the sequence needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge clock);
        n_fail++;
        test_done();
    end
endmodule

// ---- test/fwepr_assertions.sv ----
// Link checker for the register command interface
`timescale 1ns/1ps
`include "fwepr_defs.svh"
module fwepr_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Command from host
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    // Answer from device
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_err
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic wrap_wr;
    logic wrap_seen_q;
    logic [7:0] wrap_val_q;

    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    // Commands that write the volatile wrap register
    assign wrap_wr = (cmd_op == `FWEPR_OP_BURST_SET) ||
        (cmd_op == `FWEPR_OP_GEN_WR && cmd_addr == `FWEPR_ADR_WRAP_V);

    // Only a read right after a wrap write is compared, so soft reset
    // between the two must be kept out by the stimulus
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wrap_seen_q <= 1'b0;
        end else if (cmd_valid) begin
            wrap_seen_q <= wrap_wr;
        end
    end

    // Value of the last wrap write
    always_ff @(posedge clock) begin
        if (cmd_valid && wrap_wr) begin
            wrap_val_q <= cmd_wdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_wrap_rd;
        cmd_valid && cmd_op == `FWEPR_OP_GEN_RD &&
            cmd_addr == `FWEPR_ADR_WRAP_V && wrap_seen_q;
    endsequence
    sequence s_write;
        cmd_valid && (cmd_op == `FWEPR_OP_GEN_WR ||
            cmd_op == `FWEPR_OP_BURST_SET || cmd_op == `FWEPR_OP_PROT_PROG);
    endsequence
    sequence s_ecc_rd;
        cmd_valid && (cmd_op == `FWEPR_OP_ECC_RD_A ||
            cmd_op == `FWEPR_OP_ECC_RD_B);
    endsequence
    sequence s_both_lock;
        cmd_valid && cmd_op == `FWEPR_OP_PROT_PROG &&
            cmd_wdata[2:1] == `FWEPR_PROT_BOTH;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    rsp_follows_cmd_a: assert property (
        cmd_valid |=> rsp_valid)
        else $error("answer missing one cycle after command");
    rsp_needs_cmd_a: assert property (
        rsp_valid |-> $past(cmd_valid))
        else $error("answer without a command");
    cmd_spacing_a: assert property (
        cmd_valid |=> (!cmd_valid) [*2])
        else $error("commands closer than three cycles");
    write_zero_data_a: assert property (
        s_write |=> rsp_valid && rsp_data == 16'h0000)
        else $error("write answer carries data");
    ecc_byte_only_a: assert property (
        s_ecc_rd |=> rsp_valid && rsp_data[15:8] == 8'h00 && !rsp_err)
        else $error("ECC status wider than a byte");
    both_lock_reject_a: assert property (
        s_both_lock |=> rsp_valid && rsp_err)
        else $error("double mode lock not rejected");
    err_only_prog_a: assert property (
        rsp_err |-> $past(cmd_valid) &&
            ($past(cmd_op) == `FWEPR_OP_PROT_PROG ||
            $past(cmd_op) == `FWEPR_OP_GEN_WR))
        else $error("error on a command that programs nothing");
    wrap_readback_a: assert property (
        s_wrap_rd |=> rsp_valid && rsp_data ==
            {8'h00, wrap_val_q & `FWEPR_WRAP_MASK})
        else $error("wrap register read differs from last write");
endmodule
